// >>> scfl_defs.vh
/*
  constants for the serial configuration flash link master
  assumes a 20 MHz system clock and a flash answering msb first
*/
`ifndef SCFL_DEFS_VH
`define SCFL_DEFS_VH
// ----------------------------------------
// link framing
// ----------------------------------------
`define SCFL_READ_OPCODE   8'h03
`define SCFL_OPCODE_BITS   8
`define SCFL_ADDR_BITS     24
`define SCFL_CLK_DIV       4
`define SCFL_ERASED_BYTE   8'hff
// ----------------------------------------
// status handshake timing (cycles at 20 MHz)
// ----------------------------------------
`define SCFL_STATUS_PULSE_NS   2000
`define SCFL_STATUS_PULSE_CYC  ((`SCFL_STATUS_PULSE_NS + 49) / 50)
`define SCFL_INIT_CYCLES       64
`endif

// >>> scfl_fifo.v
/*
  small synchronous fifo for received configuration bytes
  assumes both sides run on clk with the synchronous active low reset
*/
`timescale 1ns/1ns
module scfl_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk,      // system clock
  input  wire             rst_b,    // synchronous reset, active low
  input  wire             in_valid, // write request
  output wire             in_ready, // space available
  input  wire [WIDTH-1:0] in_data,  // write data
  output wire             out_valid,// data available
  input  wire             out_ready,// reader accepts
  output reg  [WIDTH-1:0] out_data  // registered read data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  reg [AW:0]      cnt_q;
  reg             vld_q;
  wire            push;
  wire            pop;
  wire            load;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign push      = in_valid & in_ready;
  assign out_valid = vld_q;
  // while the fifo holds a byte, the output register is refilled whenever it is empty or being taken
  assign load      = (cnt_q != {(AW+1){1'b0}}) & (~vld_q | out_ready);
  assign pop       = load;

  always @(posedge clk)
  begin
    if (push)
      mem[wr_q[AW-1:0]] <= in_data;
    if (!rst_b)
    begin
      wr_q     <= {(AW+1){1'b0}};
      rd_q     <= {(AW+1){1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
      vld_q    <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
      begin
        rd_q     <= rd_q + 1'b1;
        out_data <= mem[rd_q[AW-1:0]];
      end
      if (push & ~pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop & ~push)
        cnt_q <= cnt_q - 1'b1;
      if (load)
        vld_q <= 1'b1;
      else if (out_ready)
        vld_q <= 1'b0;
    end
  end
endmodule

// >>> scfl_master.v
/*
  active serial configuration master: reads a configuration image from a
  serial flash and streams its bytes out, then runs the done/init handshake.
  assumes the flash changes its data on falling serial_clock edges and that
  config_complete has an external pull-up resistor.
*/
`timescale 1ns/1ns
`include "scfl_defs.vh"

// Notes on behaviour
// - the master generates serial_clock; the flash has no clock of its own
// - master drives master_select_out_n low before any transfer
// - after select, opcode then address go out on master_serial_out
// - master captures each returned bit on the following falling edge
// - missing or early config_complete makes master pulse config_status_n low
// - on success master releases open-drain config_complete for pull-up
// - initialization starts after config_complete high, then user mode
// - config_request_n is held low until flash supplies are ready
// - only first device is active serial; followers strap passive serial
// - one flash per chain; image must fit one device
// - opcodes, addresses and data travel msb first
module scfl_master #(
  parameter [23:0] START_ADDR  = 24'h000000,
  parameter [23:0] IMAGE_BYTES = 24'h000010,
  parameter        CLK_DIV     = `SCFL_CLK_DIV,
  parameter        INIT_CYCLES = `SCFL_INIT_CYCLES
) (
  input  wire       clk,                  // system clock, 20 MHz
  input  wire       rst_b,                // synchronous reset, active low
  input  wire       config_request_n,     // pin: low holds off configuration
  input  wire [1:0] config_scheme_strap,  // pin strap: 2'h1 active serial, else idle
  output reg        serial_clock,         // link clock to flash
  output reg        master_select_out_n,  // flash chip select, active low
  output reg        master_serial_out,    // opcode/address to flash
  input  wire       master_serial_in,     // data from flash (pin)
  output reg        config_status_n,      // status, active low pulse on error
  input  wire       config_complete_in,   // done pin level
  output reg        config_complete_out,  // done pin drive value (low)
  output reg        config_complete_oe,   // done pin enable, high while driving
  output wire       data_valid,           // configuration byte available
  input  wire       data_ready,           // consumer accepts byte
  output wire [7:0] data_byte,            // configuration byte
  output reg        user_mode,            // configuration and init finished
  output reg        erased_seen           // every byte read so far was 8'hff
);
  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_CMD  = 3'h1;
  localparam [2:0] ST_DATA = 3'h2;
  localparam [2:0] ST_END  = 3'h3;
  localparam [2:0] ST_ERR  = 3'h4;
  localparam [2:0] ST_INIT = 3'h5;
  localparam [2:0] ST_USER = 3'h6;
  localparam [1:0] STRAP_AS = 2'h1;
  localparam [7:0] READ_OP = `SCFL_READ_OPCODE;
  localparam integer PULSE_INT = `SCFL_STATUS_PULSE_CYC;
  localparam [15:0] PULSE_CYC = PULSE_INT[15:0];

  reg  [2:0]  state_q;
  reg  [7:0]  div_q;
  reg  [5:0]  bit_q;
  reg  [31:0] cmd_q;
  reg  [7:0]  shift_q;
  reg  [2:0]  rx_cnt_q;
  reg  [23:0] bytes_q;
  reg  [15:0] wait_q;
  reg         rx_ok_q;
  reg  [7:0]  byte_q;
  reg         req_m_q, req_q, din_m_q, din_q, done_m_q, done_q;
  reg  [1:0]  strap_m_q, strap_q;
  wire        fifo_ready;
  wire        fall;
  wire        rise;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      req_m_q  <= 1'b0;
      req_q    <= 1'b0;
      din_m_q  <= 1'b1;
      din_q    <= 1'b1;
      done_m_q <= 1'b0;
      done_q   <= 1'b0;
      // a strap of 0 keeps the master idle until the real strap is through
      strap_m_q <= 2'h0;
      strap_q   <= 2'h0;
    end
    else
    begin
      req_m_q  <= config_request_n;
      req_q    <= req_m_q;
      din_m_q  <= master_serial_in;
      din_q    <= din_m_q;
      done_m_q <= config_complete_in;
      done_q   <= done_m_q;
      strap_m_q <= config_scheme_strap;
      strap_q   <= strap_m_q;
    end
  end

  // divider phases; a falling edge is only taken when the fifo can absorb a
  // byte, so back-pressure simply stretches serial_clock high
  assign rise = (div_q == CLK_DIV[7:0] - 8'h1) & ~serial_clock;
  assign fall = (div_q == CLK_DIV[7:0] - 8'h1) & serial_clock & fifo_ready;

  // ----------------------------------------
  // transfer state machine
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q             <= ST_IDLE;
      div_q               <= 8'h0;
      bit_q               <= 6'h0;
      cmd_q               <= 32'h0;
      shift_q             <= 8'h0;
      rx_cnt_q            <= 3'h0;
      bytes_q             <= 24'h0;
      wait_q              <= 16'h0;
      rx_ok_q             <= 1'b0;
      byte_q              <= 8'h0;
      serial_clock        <= 1'b0;
      master_select_out_n <= 1'b1;
      master_serial_out   <= 1'b0;
      config_status_n     <= 1'b1;
      config_complete_out <= 1'b0;
      config_complete_oe  <= 1'b1;
      user_mode           <= 1'b0;
      erased_seen         <= 1'b1;
    end
    else
    begin
      rx_ok_q <= 1'b0;
      if (state_q == ST_CMD || state_q == ST_DATA)
      begin
        if (rise || fall)
          div_q <= 8'h0;
        else if (div_q != CLK_DIV[7:0] - 8'h1)
          div_q <= div_q + 8'h1;
      end
      case (state_q)
        ST_IDLE:
        begin
          // hold off while request is low or strap is not active serial
          if (req_q && strap_q == STRAP_AS)
          begin
            master_select_out_n <= 1'b0;
            cmd_q               <= {`SCFL_READ_OPCODE, START_ADDR};
            master_serial_out   <= READ_OP[7];
            bit_q               <= 6'h0;
            bytes_q             <= 24'h0;
            // the done timeout reuses wait_q, so it must not start from a stale count
            wait_q              <= 16'h0;
            div_q               <= 8'h0;
            erased_seen         <= 1'b1;
            state_q             <= ST_CMD;
          end
        end
        ST_CMD:
        begin
          if (rise)
            serial_clock <= 1'b1;
          else if (fall)
          begin
            serial_clock <= 1'b0;
            cmd_q        <= {cmd_q[30:0], 1'b0};
            master_serial_out <= cmd_q[30];
            bit_q        <= bit_q + 6'h1;
            if (bit_q == `SCFL_OPCODE_BITS + `SCFL_ADDR_BITS - 1)
            begin
              rx_cnt_q <= 3'h0;
              state_q  <= ST_DATA;
            end
          end
        end
        ST_DATA:
        begin
          if (rise)
            serial_clock <= 1'b1;
          else if (fall)
          begin
            serial_clock <= 1'b0;
            // the edge that ends the last address bit launches the first data
            // bit, so each fall here latches the bit launched one fall before
            shift_q  <= {shift_q[6:0], din_q};
            rx_cnt_q <= rx_cnt_q + 3'h1;
            if (rx_cnt_q == 3'h7)
            begin
              byte_q  <= {shift_q[6:0], din_q};
              rx_ok_q <= 1'b1;
              if ({shift_q[6:0], din_q} != `SCFL_ERASED_BYTE)
                erased_seen <= 1'b0;
              bytes_q <= bytes_q + 24'h1;
              if (bytes_q == IMAGE_BYTES - 24'h1)
                state_q <= ST_END;
            end
          end
          if (done_q)
          begin
            master_select_out_n <= 1'b1;
            serial_clock        <= 1'b0;
            wait_q              <= 16'h0;
            state_q             <= ST_ERR;
          end
        end
        ST_END:
        begin
          master_select_out_n <= 1'b1;
          config_complete_oe  <= 1'b0;
          wait_q              <= wait_q + 16'h1;
          if (done_q)
          begin
            wait_q  <= 16'h0;
            state_q <= ST_INIT;
          end
          else if (wait_q == PULSE_CYC)
          begin
            wait_q  <= 16'h0;
            state_q <= ST_ERR;
          end
        end
        ST_ERR:
        begin
          config_complete_oe <= 1'b1;
          config_status_n    <= 1'b0;
          wait_q             <= wait_q + 16'h1;
          if (wait_q == PULSE_CYC)
          begin
            config_status_n <= 1'b1;
            state_q         <= ST_IDLE;
          end
        end
        ST_INIT:
        begin
          wait_q <= wait_q + 16'h1;
          if (wait_q == INIT_CYCLES[15:0] - 16'h1)
            state_q <= ST_USER;
        end
        ST_USER:
        begin
          user_mode <= 1'b1;
          if (!req_q)
          begin
            user_mode          <= 1'b0;
            config_complete_oe <= 1'b1;
            state_q            <= ST_IDLE;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // received byte buffer
  // ----------------------------------------
  scfl_fifo #(
    .WIDTH (8),
    .DEPTH (4),
    .AW    (2)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (rx_ok_q),
    .in_ready  (fifo_ready),
    .in_data   (byte_q),
    .out_valid (data_valid),
    .out_ready (data_ready),
    .out_data  (data_byte)
  );
endmodule

// >>> scfl_flash_model.sv
/*
  behavioural serial configuration flash answering the link master
  assumes the master alone makes serial_clock and drives select
*/
`timescale 1ns/1ns
module scfl_flash_model (
  input  wire        serial_clock,     // link clock from the master
  input  wire        flash_select_n,   // chip select, active low
  input  wire        flash_serial_in,  // command and address bits
  input  wire        erased,           // 1: array still blank
  output reg         flash_serial_out, // data back to the master
  output reg  [31:0] cmd_q             // last command word taken in
);
  integer cnt;
  integer k;
  function [7:0] pat(input [23:0] a);
    pat = a[7:0] * 8'h1d ^ 8'h5a;
  endfunction
  initial
  begin
    cnt = 0;
    cmd_q = 32'h0;
    flash_serial_out = 1'b1;
  end
  // no clock of its own: everything hangs on the master's edges
  always @(posedge serial_clock)
    if (!flash_select_n)
    begin
      if (cnt < 32)
        cmd_q <= {cmd_q[30:0], flash_serial_in};
      cnt = cnt + 1;
    end
  always @(negedge serial_clock)
    if (!flash_select_n && cnt >= 32)
    begin
      k = cnt - 32;
      flash_serial_out <= erased ? 1'b1 : pat(cmd_q[23:0] + k / 8) >> (7 - k % 8);
    end
  // a floating wire settles anywhere, so show the opposite of the last bit
  always @(posedge flash_select_n)
  begin
    cnt = 0;
    flash_serial_out <= ~flash_serial_out;
  end
endmodule

// >>> scfl_master_asserts.sv
/*
  concurrent checks on the ports of the configuration link master
  assumes one clock domain and the synchronous active low reset
*/
`timescale 1ns/1ns
module scfl_master_asserts #(
  parameter INIT_CYCLES = 64
) (
  input logic       clk,                 // system clock
  input logic       rst_b,               // reset, active low
  input logic       config_request_n,    // hold-off pin
  input logic [1:0] config_scheme_strap, // scheme strap
  input logic       serial_clock,        // link clock
  input logic       master_select_out_n, // flash select
  input logic       master_serial_out,   // command bits
  input logic       config_status_n,     // status pulse
  input logic       config_complete_in,  // done wire level
  input logic       config_complete_oe,  // done drive enable
  input logic       data_valid,          // stream valid
  input logic       data_ready,          // stream ready
  input logic [7:0] data_byte,           // stream data
  input logic       user_mode            // configured
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  reg [7:0] low_q;
  always @(posedge clk)
    low_q <= (!rst_b || config_status_n) ? 8'h00 : low_q + 8'h01;
  chk_idle_hold: assert property ((!config_request_n)[*4] |-> master_select_out_n)
    else $error("select while request held low");
  chk_passive_idle: assert property ((config_scheme_strap != 2'h1)[*4] |-> master_select_out_n)
    else $error("select under passive strap");
  chk_clock_framed: assert property (serial_clock |-> !master_select_out_n)
    else $error("link clock outside a frame");
  chk_low_phase: assert property ($fell(serial_clock) |-> (!serial_clock)[*4])
    else $error("link clock low phase short");
  chk_high_phase: assert property ($rose(serial_clock) |-> serial_clock[*4])
    else $error("link clock high phase short");
  chk_out_on_fall: assert property (!master_select_out_n && $past(!master_select_out_n)
    && $changed(master_serial_out) |-> $fell(serial_clock))
    else $error("command bit moved off a falling edge");
  chk_status_width: assert property ($rose(config_status_n) |-> low_q == 8'h28)
    else $error("status pulse width wrong");
  chk_done_release: assert property ($fell(config_complete_oe) |-> master_select_out_n)
    else $error("done released inside a frame");
  chk_init_after: assert property ($rose(user_mode) |-> !config_complete_oe
    && $past(config_complete_in, INIT_CYCLES))
    else $error("user mode before done and init");
  chk_valid_hold: assert property (data_valid && !data_ready |=> data_valid && $stable(data_byte))
    else $error("stream byte dropped while stalled");
  cover property ($rose(user_mode));
  cover property ($fell(config_status_n));
  cover property (data_valid && !data_ready);
endmodule

// >>> tb_top.sv
/*
  self-checking bench for the configuration link master with a flash model
  assumes a 50 ns clock and a pull-up on the done wire
*/
`timescale 1ns/1ns
module tb_top;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  logic       req_n = 1'b0;
  logic [1:0] strap = 2'h1;
  logic       ready = 1'b0;
  logic       hold_low = 1'b0;
  logic       hold_high = 1'b0;
  logic       erased = 1'b0;
  wire        sclk, sel_n, mosi, miso, stat_n, done_out, done_oe, valid, umode, eseen;
  wire [7:0]  dbyte;
  wire [31:0] cmd;
  // the done wire: pulled up unless someone drives it low
  // hold_high stands for the done wire going high too soon during the data phase
  wire        done_lvl = hold_high ? 1'b1 : (((done_oe && !done_out) || hold_low) ? 1'b0 : 1'b1);
  integer     num_errors = 0;
  integer     n_compared = 0;
  always #25 clk = ~clk;
  scfl_master #(.INIT_CYCLES(4)) i_scfl_master (.clk(clk), .rst_b(rst_b), .config_request_n(req_n),
    .config_scheme_strap(strap), .serial_clock(sclk), .master_select_out_n(sel_n),
    .master_serial_out(mosi), .master_serial_in(miso), .config_status_n(stat_n),
    .config_complete_in(done_lvl), .config_complete_out(done_out), .config_complete_oe(done_oe),
    .data_valid(valid), .data_ready(ready), .data_byte(dbyte), .user_mode(umode), .erased_seen(eseen));
  scfl_flash_model i_scfl_flash_model (.serial_clock(sclk), .flash_select_n(sel_n),
    .flash_serial_in(mosi), .erased(erased), .flash_serial_out(miso), .cmd_q(cmd));
  function [7:0] pat(input [23:0] a);
    pat = a[7:0] * 8'h1d ^ 8'h5a;
  endfunction
  task tick;
    @(posedge clk);
    #5;
  endtask
  task check(input [31:0] seen, input [31:0] exp, input [8*16-1:0] msg);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t %0s", $time, msg);
    end
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task bound(input ok);
    if (!ok)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t wait ran out", $time);
      conclude;
    end
  endtask
  task restart(input r, input [1:0] s);
    rst_b = 1'b0;
    req_n = r;
    strap = s;
    repeat (12) tick;
    rst_b = 1'b1;
  endtask
  // reads the whole image, stalling the stream first so the fifo fills
  task read_image(input e);
    integer i, w;
    erased = e;
    ready = 1'b0;
    restart(1'b1, 2'h1);
    repeat (1200) tick;
    ready = 1'b1;
    i = 0;
    // ready stays high, so a byte standing now is taken at the next edge
    for (w = 0; w < 20000 && i < 16; w = w + 1)
    begin
      if (valid === 1'b1)
      begin
        check(dbyte, e ? 8'hff : pat(i), "image byte");
        i = i + 1;
      end
      tick;
    end
    bound(i == 16);
    check(cmd, 32'h03000000, "read command");
  endtask
  task t_hold;
    integer w;
    restart(1'b0, 2'h1);
    for (w = 0; w < 100; w = w + 1)
    begin
      tick;
      check(sel_n, 1'b1, "select too soon");
    end
    check(sclk, 1'b0, "clock idle");
    check(done_out, 1'b0, "done drive");
    req_n = 1'b1;
    strap = 2'h2;
    repeat (100) tick;
    check(sel_n, 1'b1, "passive selected");
    $display("hold test done");
  endtask
  task t_boot(input e);
    integer w;
    read_image(e);
    for (w = 0; w < 400 && umode !== 1'b1; w = w + 1)
      tick;
    bound(umode === 1'b1);
    check(done_oe, 1'b0, "done not free");
    check(stat_n, 1'b1, "status pulsed");
    check(eseen, e, "erased flag");
    req_n = 1'b0;
    repeat (5) tick;
    check(umode, 1'b0, "user mode kept");
    check(done_oe, 1'b1, "done not held");
    $display("boot test done");
  endtask
  // stall the stream so the link sits in the data phase, then raise done
  task t_early;
    integer w;
    ready = 1'b0;
    restart(1'b1, 2'h1);
    repeat (1000) tick;
    hold_high = 1'b1;
    for (w = 0; w < 100 && stat_n !== 1'b0; w = w + 1)
      tick;
    bound(stat_n === 1'b0);
    check(sel_n, 1'b1, "select kept");
    check(done_oe, 1'b1, "done released");
    check(umode, 1'b0, "user mode early");
    hold_high = 1'b0;
    $display("early done test done");
  endtask
  task t_fail;
    integer w;
    hold_low = 1'b1;
    read_image(1'b0);
    for (w = 0; w < 400 && stat_n !== 1'b0; w = w + 1)
      tick;
    bound(stat_n === 1'b0);
    check(umode, 1'b0, "user mode early");
    repeat (60) tick;
    hold_low = 1'b0;
    $display("failed done test done");
  endtask
  initial
  begin
    t_hold;
    t_boot(1'b0);
    t_boot(1'b1);
    t_early;
    t_fail;
    conclude;
  end
endmodule
bind scfl_master scfl_master_asserts #(.INIT_CYCLES(INIT_CYCLES)) i_scfl_master_asserts (
  .clk                 (clk),
  .rst_b               (rst_b),
  .config_request_n    (config_request_n),
  .config_scheme_strap (config_scheme_strap),
  .serial_clock        (serial_clock),
  .master_select_out_n (master_select_out_n),
  .master_serial_out   (master_serial_out),
  .config_status_n     (config_status_n),
  .config_complete_in  (config_complete_in),
  .config_complete_oe  (config_complete_oe),
  .data_valid          (data_valid),
  .data_ready          (data_ready),
  .data_byte           (data_byte),
  .user_mode           (user_mode)
);
